// ### rtl/rmp_pin_config.sv
// reset-time memory mode capture and pin function multiplexing
`timescale 1ns/100ps
// Summary of operation
// - strap level during reset fixes memory mode
// - strap low: 14-bit address, 24-bit data
// - byte access puts address on upper data
// - strap high: 16-bit host port, one address
// - host drives strobes, device drives acknowledge
// - mode pin 2 sampled in reset, then a flag
// - interrupt and flag functions live concurrently
// - enabled interrupt fires when pin asserted
// - control field picks serial or flag/interrupt
// - bus fixed at reset, serial pins reconfigurable
module rmp_pin_config (
  // clock and reset
  input  wire logic                                  i_clk_sys,
  input  wire logic                                  i_reset_n,
  // register port
  input  wire logic [rmp_pkg::REG_ADDR_W-1:0]        i_reg_addr,
  input  wire logic [rmp_pkg::REG_DATA_W-1:0]        i_reg_wdata,
  input  wire logic                                  i_reg_write,
  input  wire logic                                  i_reg_read,
  output logic      [rmp_pkg::REG_DATA_W-1:0]        o_reg_rdata,
  // core side of the external bus
  input  wire logic [rmp_pkg::ADDR_BUS_W-1:0]        i_core_addr,
  input  wire logic [rmp_pkg::DATA_BUS_W-1:0]        i_core_wdata,
  input  wire logic                                  i_core_data_drive,
  input  wire logic                                  i_core_byte_access,
  input  wire logic [rmp_pkg::BYTE_ADDR_W-1:0]       i_core_byte_addr,
  output logic      [rmp_pkg::DATA_BUS_W-1:0]        o_core_rdata,
  output logic                                       o_mode_host,
  // external memory pins
  output logic      [rmp_pkg::ADDR_BUS_W-1:0]        o_external_address_bus,
  input  wire logic [rmp_pkg::DATA_BUS_W-1:0]        i_external_data_bus,
  output logic      [rmp_pkg::DATA_BUS_W-1:0]        o_external_data_bus,
  output logic      [rmp_pkg::DATA_BUS_W-1:0]        o_external_data_bus_oe_n,
  // host port pins
  input  wire logic [rmp_pkg::HOST_BUS_W-1:0]        i_host_port_addr_data_bus,
  output logic      [rmp_pkg::HOST_BUS_W-1:0]        o_host_port_addr_data_bus,
  output logic      [rmp_pkg::HOST_BUS_W-1:0]        o_host_port_addr_data_bus_oe_n,
  input  wire logic                                  i_host_port_select_n,
  input  wire logic                                  i_host_port_addr_latch,
  input  wire logic                                  i_host_port_read_strobe_n,
  input  wire logic                                  i_host_port_write_strobe_n,
  output logic                                       o_host_port_ack_n,
  // core side of the host port
  input  wire logic [rmp_pkg::HOST_BUS_W-1:0]        i_core_host_rdata,
  input  wire logic                                  i_core_host_drive,
  input  wire logic                                  i_core_host_ack,
  output logic      [rmp_pkg::HOST_BUS_W-1:0]        o_core_host_bus,
  output logic                                       o_core_host_select,
  output logic                                       o_core_host_addr_latch,
  output logic                                       o_core_host_read,
  output logic                                       o_core_host_write,
  // shared flag pins: 2 mode strap, 4..7 interrupt pins
  input  wire logic [rmp_pkg::FLAG_W-1:0]            i_shared_flag_pin,
  output logic      [rmp_pkg::FLAG_W-1:0]            o_shared_flag_pin,
  output logic      [rmp_pkg::FLAG_W-1:0]            o_shared_flag_pin_oe_n,
  // second serial port pins
  input  wire logic                                  i_sp1_data_in,
  input  wire logic                                  i_sp1_rfs_in,
  input  wire logic                                  i_sp1_tfs_in,
  output logic                                       o_sp1_data_out,
  // core side of the second serial port
  input  wire logic                                  i_core_sp1_tx,
  output logic                                       o_core_sp1_rx,
  output logic                                       o_core_sp1_rfs,
  output logic                                       o_core_sp1_tfs,
  // interrupt requests to the sequencer: 3..0 shared pins, 5..4 serial alt
  output logic      [rmp_pkg::IRQ_W-1:0]             o_irq_request
);

  // ==========================================================
  // pin synchronisers
  logic [rmp_pkg::FLAG_W-1:0]     flag_meta_reg, flag_sync_reg;
  logic [rmp_pkg::HOST_BUS_W-1:0] hbus_meta_reg, hbus_sync_reg;
  logic [3:0]                     hctl_meta_reg, hctl_sync_reg;
  logic [2:0]                     sp_meta_reg,   sp_sync_reg;
  logic [rmp_pkg::DATA_BUS_W-1:0] dbus_meta_reg, dbus_sync_reg;

  // two stages on every pin input; nothing reads the first stage
  always_ff @(posedge i_clk_sys) begin
    flag_meta_reg <= i_shared_flag_pin;
    flag_sync_reg <= flag_meta_reg;
    hbus_meta_reg <= i_host_port_addr_data_bus;
    hbus_sync_reg <= hbus_meta_reg;
    hctl_meta_reg <= {i_host_port_select_n, i_host_port_addr_latch,
                      i_host_port_read_strobe_n, i_host_port_write_strobe_n};
    hctl_sync_reg <= hctl_meta_reg;
    sp_meta_reg   <= {i_sp1_data_in, i_sp1_rfs_in, i_sp1_tfs_in};
    sp_sync_reg   <= sp_meta_reg;
    dbus_meta_reg <= i_external_data_bus;
    dbus_sync_reg <= dbus_meta_reg;
  end

  // ==========================================================
  // memory mode latch
  rmp_pkg::rmp_mode_t mode_reg;

  // follows the strap only while reset is held, so the last sample
  // before release is kept; strap changes later are ignored
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      mode_reg <= flag_sync_reg[rmp_pkg::STRAP_PIN] ? rmp_pkg::RMP_MODE_HOST
                                                    : rmp_pkg::RMP_MODE_FULL;
    end
  end

  wire host_mode = (mode_reg == rmp_pkg::RMP_MODE_HOST);
  assign o_mode_host = host_mode;

  // ==========================================================
  // software registers
  logic [rmp_pkg::FLAG_W-1:0] flag_dir_reg;
  logic [rmp_pkg::FLAG_W-1:0] flag_out_reg;
  logic                       serial_alt_reg;
  logic [rmp_pkg::IRQ_W-1:0]  irq_mask_reg;
  logic [rmp_pkg::REG_DATA_W-1:0] rdata_reg;

  wire wr_dir  = i_reg_write && (i_reg_addr == rmp_pkg::OFS_FLAG_DIR);
  wire wr_out  = i_reg_write && (i_reg_addr == rmp_pkg::OFS_FLAG_OUT);
  wire wr_sys  = i_reg_write && (i_reg_addr == rmp_pkg::OFS_SYS_CTRL);
  wire wr_mask = i_reg_write && (i_reg_addr == rmp_pkg::OFS_IRQ_MASK);

  // flags start as inputs so a strap driver owns the pin in reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      flag_dir_reg   <= rmp_pkg::RST_FLAG_DIR;
      flag_out_reg   <= rmp_pkg::RST_FLAG_OUT;
      serial_alt_reg <= rmp_pkg::RST_SYS_ALT;
      irq_mask_reg   <= rmp_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_dir)  flag_dir_reg   <= i_reg_wdata[rmp_pkg::FLAG_W-1:0];
      if (wr_out)  flag_out_reg   <= i_reg_wdata[rmp_pkg::FLAG_W-1:0];
      if (wr_sys)  serial_alt_reg <= i_reg_wdata[rmp_pkg::SYS_SERIAL_ALT_BIT];
      if (wr_mask) irq_mask_reg   <= i_reg_wdata[rmp_pkg::IRQ_W-1:0];
    end
  end

  // ==========================================================
  // shared flag and interrupt pins
  // flag pins keep their programmable role after reset
  assign o_shared_flag_pin      = flag_out_reg;
  assign o_shared_flag_pin_oe_n = ~flag_dir_reg;

  // a pin counts as asserted when it reads low or we drive it low,
  // so a software-set flag raises its interrupt just like a pin would
  wire [rmp_pkg::FLAG_W-1:0] pin_low = ~flag_sync_reg | (flag_dir_reg & ~flag_out_reg);

  wire [rmp_pkg::SHARED_IRQ_N-1:0] shared_raw = pin_low[rmp_pkg::EDGE_OR_LEVEL_IRQ_PIN_POS:rmp_pkg::EDGE_IRQ_PIN_POS];
  wire sp_fi   = sp_sync_reg[2];
  wire sp_irq0 = serial_alt_reg & ~sp_sync_reg[1];
  wire sp_irq1 = serial_alt_reg & ~sp_sync_reg[0];
  wire [rmp_pkg::IRQ_W-1:0] irq_raw = {sp_irq1, sp_irq0, shared_raw};

  logic [rmp_pkg::IRQ_W-1:0] irq_req_reg;

  // masked requests; level follows the pin three cycles later
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      irq_req_reg <= '0;
    end else begin
      irq_req_reg <= irq_raw & irq_mask_reg;
    end
  end
  assign o_irq_request = irq_req_reg;

  // ==========================================================
  // second serial port function select
  assign o_core_sp1_rx  = serial_alt_reg ? 1'b0 : sp_sync_reg[2];
  assign o_core_sp1_rfs = serial_alt_reg ? 1'b0 : sp_sync_reg[1];
  assign o_core_sp1_tfs = serial_alt_reg ? 1'b0 : sp_sync_reg[0];

  logic sp_tx_reg;

  // flag output reuses the transmit pin when the alternate role is set
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sp_tx_reg <= 1'b0;
    end else begin
      sp_tx_reg <= serial_alt_reg ? flag_out_reg[3] : i_core_sp1_tx;
    end
  end
  assign o_sp1_data_out = sp_tx_reg;

  // ==========================================================
  // external memory bus
  localparam int unsigned BYTE_LSB = rmp_pkg::DATA_BUS_W - rmp_pkg::BYTE_ADDR_W;
  localparam int unsigned HOST_LO  = rmp_pkg::DATA_BUS_W - rmp_pkg::HOST_BUS_W;

  wire [rmp_pkg::DATA_BUS_W-1:0] data_full =
    i_core_byte_access ? {i_core_byte_addr, i_core_wdata[BYTE_LSB-1:0]} : i_core_wdata;
  // host mode: only the lowest address pin stays; peripheral decode is external
  wire [rmp_pkg::ADDR_BUS_W-1:0] addr_next =
    host_mode ? {{(rmp_pkg::ADDR_BUS_W-1){1'b0}}, i_core_addr[0]} : i_core_addr;
  // byte access drives the upper lines even on a read, as they carry address
  wire [rmp_pkg::DATA_BUS_W-1:0] drive_full =
    {{rmp_pkg::BYTE_ADDR_W{i_core_data_drive | i_core_byte_access}},
     {BYTE_LSB{i_core_data_drive}}};
  wire [rmp_pkg::DATA_BUS_W-1:0] drive_host =
    {{rmp_pkg::HOST_BUS_W{i_core_data_drive}}, {HOST_LO{1'b0}}};
  wire [rmp_pkg::DATA_BUS_W-1:0] drive_next = host_mode ? drive_host : drive_full;

  logic [rmp_pkg::ADDR_BUS_W-1:0] ext_addr_reg;
  logic [rmp_pkg::DATA_BUS_W-1:0] ext_data_reg, ext_drive_reg;

  // external pins registered; nothing driven in reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ext_addr_reg  <= '0;
      ext_data_reg  <= '0;
      ext_drive_reg <= '0;
    end else begin
      ext_addr_reg  <= addr_next;
      ext_data_reg  <= data_full;
      ext_drive_reg <= drive_next;
    end
  end
  assign o_external_address_bus   = ext_addr_reg;
  assign o_external_data_bus      = ext_data_reg;
  assign o_external_data_bus_oe_n = ~ext_drive_reg;
  // undriven lines in host mode read back as zero
  assign o_core_rdata = host_mode ? {dbus_sync_reg[rmp_pkg::DATA_BUS_W-1:HOST_LO], {HOST_LO{1'b0}}}
                                  : dbus_sync_reg;

  // ==========================================================
  // host port
  // strobes are active low at the pins; ignored entirely in full mode
  assign o_core_host_select     = host_mode & ~hctl_sync_reg[3];
  assign o_core_host_addr_latch = host_mode &  hctl_sync_reg[2];
  assign o_core_host_read       = host_mode & ~hctl_sync_reg[3] & ~hctl_sync_reg[1];
  assign o_core_host_write      = host_mode & ~hctl_sync_reg[3] & ~hctl_sync_reg[0];
  assign o_core_host_bus        = host_mode ? hbus_sync_reg : '0;

  logic [rmp_pkg::HOST_BUS_W-1:0] hp_data_reg;
  logic                           hp_drive_reg;
  logic                           hp_ack_reg;

  // registered port outputs; acknowledge idles high
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      hp_data_reg  <= '0;
      hp_drive_reg <= 1'b0;
      hp_ack_reg   <= 1'b0;
    end else begin
      hp_data_reg  <= i_core_host_rdata;
      hp_drive_reg <= host_mode & i_core_host_drive;
      hp_ack_reg   <= host_mode & i_core_host_ack;
    end
  end
  assign o_host_port_addr_data_bus      = hp_data_reg;
  assign o_host_port_addr_data_bus_oe_n = {rmp_pkg::HOST_BUS_W{~hp_drive_reg}};
  assign o_host_port_ack_n              = ~hp_ack_reg;

  // ==========================================================
  // register read, data valid the cycle after the strobe
  wire [rmp_pkg::REG_DATA_W-1:0] status_word =
    {{(rmp_pkg::REG_DATA_W-rmp_pkg::STAT_IRQ_LSB-rmp_pkg::IRQ_W){1'b0}},
     irq_raw, sp_fi & serial_alt_reg, host_mode};
  wire [rmp_pkg::REG_DATA_W-1:0] pad_flag = '0;
  logic [rmp_pkg::REG_DATA_W-1:0] rd_sel;
  always_comb begin
    rd_sel = '0;
    if (i_reg_addr == rmp_pkg::OFS_FLAG_DIR)      rd_sel = {pad_flag[15:8], flag_dir_reg};
    else if (i_reg_addr == rmp_pkg::OFS_FLAG_OUT) rd_sel = {pad_flag[15:8], flag_out_reg};
    else if (i_reg_addr == rmp_pkg::OFS_FLAG_IN)  rd_sel = {pad_flag[15:8], flag_sync_reg};
    else if (i_reg_addr == rmp_pkg::OFS_SYS_CTRL) rd_sel = {pad_flag[15:1], serial_alt_reg};
    else if (i_reg_addr == rmp_pkg::OFS_IRQ_MASK) rd_sel = {pad_flag[15:6], irq_mask_reg};
    else if (i_reg_addr == rmp_pkg::OFS_STATUS)   rd_sel = status_word;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_reg_read ? rd_sel : '0;
    end
  end
  assign o_reg_rdata = rdata_reg;

endmodule : rmp_pin_config

// ### rtl/rmp_pkg.sv
// constants for the reset-mode and pin-function block
package rmp_pkg;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_BUS_W   = 14;
  localparam int unsigned DATA_BUS_W   = 24;
  localparam int unsigned BYTE_ADDR_W  = 8;
  localparam int unsigned HOST_BUS_W   = 16;
  localparam int unsigned FLAG_W       = 8;
  localparam int unsigned IRQ_W        = 6;
  localparam int unsigned REG_ADDR_W   = 4;
  localparam int unsigned REG_DATA_W   = 16;

  // ==========================================================
  // pin positions inside the shared flag vector
  localparam int unsigned STRAP_PIN    = 2;  // memory-mode strap
  localparam int unsigned EDGE_IRQ_PIN_POS     = 4;  // edge interrupt pin
  localparam int unsigned LEVEL_IRQ_PIN_A_POS    = 5;
  localparam int unsigned LEVEL_IRQ_PIN_B_POS    = 6;
  localparam int unsigned EDGE_OR_LEVEL_IRQ_PIN_POS     = 7;
  localparam int unsigned SHARED_IRQ_N = 4;

  // ==========================================================
  // register offsets
  localparam logic [REG_ADDR_W-1:0] OFS_FLAG_DIR  = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_FLAG_OUT  = 4'h1;
  localparam logic [REG_ADDR_W-1:0] OFS_FLAG_IN   = 4'h2;
  localparam logic [REG_ADDR_W-1:0] OFS_SYS_CTRL  = 4'h3;
  localparam logic [REG_ADDR_W-1:0] OFS_IRQ_MASK  = 4'h4;
  localparam logic [REG_ADDR_W-1:0] OFS_STATUS    = 4'h5;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned SYS_SERIAL_ALT_BIT = 0;  // 1: flag/interrupt use
  localparam int unsigned STAT_MODE_BIT      = 0;
  localparam int unsigned STAT_ALT_FI_BIT    = 1;
  localparam int unsigned STAT_IRQ_LSB       = 2;
  localparam logic [FLAG_W-1:0] RST_FLAG_DIR = 8'h00;  // all inputs
  localparam logic [FLAG_W-1:0] RST_FLAG_OUT = 8'h00;
  localparam logic              RST_SYS_ALT  = 1'b0;   // serial function
  localparam logic [IRQ_W-1:0]  RST_IRQ_MASK = 6'h00;

  // memory modes
  typedef enum logic {
    RMP_MODE_FULL,
    RMP_MODE_HOST
  } rmp_mode_t;
endpackage : rmp_pkg

// ### verif/rmp_ext_side.sv
// board model of the shared flag pins: strap driver, interrupt sources, pull-ups
`timescale 1ns/100ps
module rmp_ext_side (
  // reset and stimulus
  input  wire logic       i_reset_n,
  input  wire logic       i_strap_level,
  input  wire logic [7:0] i_ext_low,
  // device pin drive
  input  wire logic [7:0] i_dev_out,
  input  wire logic [7:0] i_dev_oe_n,
  // resolved pin levels
  output logic      [7:0] o_pin_level
);
  // ====================
  // pin resolution
  wire logic strap_en = !i_reset_n;
  // device wins, then strap driver, else source pulls low or weak pull-up
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (!i_dev_oe_n[k]) o_pin_level[k] = i_dev_out[k];
      else if (k == rmp_pkg::STRAP_PIN && strap_en) o_pin_level[k] = i_strap_level;
      else o_pin_level[k] = !i_ext_low[k];
    end
  end
endmodule : rmp_ext_side

// ### verif/rmp_pin_config_bench.sv
// self-checking bench for the reset-mode and pin-function block
`timescale 1ns/100ps
module rmp_pin_config_bench;
  // ====================
  // stimulus and observed signals
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0, strap_lvl = 1'b0;
  logic i_core_data_drive = 1'b0, i_core_byte_access = 1'b0, i_host_port_addr_latch = 1'b0;
  logic i_core_host_drive = 1'b0, i_core_host_ack = 1'b0, i_sp1_data_in = 1'b0, i_core_sp1_tx = 1'b0;
  logic i_host_port_select_n = 1'b1, i_host_port_read_strobe_n = 1'b1, i_host_port_write_strobe_n = 1'b1;
  logic i_sp1_rfs_in = 1'b1, i_sp1_tfs_in = 1'b1;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [7:0]  i_core_byte_addr = 8'h00, ext_low = 8'h00, i_shared_flag_pin, o_shared_flag_pin, o_shared_flag_pin_oe_n;
  logic [13:0] i_core_addr = 14'h0000, o_external_address_bus;
  logic [15:0] i_reg_wdata = 16'h0000, i_host_port_addr_data_bus = 16'h0000, i_core_host_rdata = 16'h0000;
  logic [15:0] o_reg_rdata, o_host_port_addr_data_bus, o_host_port_addr_data_bus_oe_n, o_core_host_bus;
  logic [23:0] i_core_wdata = 24'h000000, i_external_data_bus = 24'h000000;
  logic [23:0] o_core_rdata, o_external_data_bus, o_external_data_bus_oe_n;
  logic o_mode_host, o_host_port_ack_n, o_core_host_select, o_core_host_addr_latch, o_core_host_read;
  logic o_core_host_write, o_sp1_data_out, o_core_sp1_rx, o_core_sp1_rfs, o_core_sp1_tfs;
  logic [5:0]  o_irq_request;
  int num_errors = 0, n_checks = 0, cycles = 0;

  rmp_pin_config rmp_pin_config_i (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
    .o_reg_rdata, .i_core_addr, .i_core_wdata, .i_core_data_drive, .i_core_byte_access, .i_core_byte_addr,
    .o_core_rdata, .o_mode_host, .o_external_address_bus, .i_external_data_bus, .o_external_data_bus,
    .o_external_data_bus_oe_n, .i_host_port_addr_data_bus, .o_host_port_addr_data_bus,
    .o_host_port_addr_data_bus_oe_n, .i_host_port_select_n, .i_host_port_addr_latch, .i_host_port_read_strobe_n,
    .i_host_port_write_strobe_n, .o_host_port_ack_n, .i_core_host_rdata, .i_core_host_drive, .i_core_host_ack,
    .o_core_host_bus, .o_core_host_select, .o_core_host_addr_latch, .o_core_host_read, .o_core_host_write,
    .i_shared_flag_pin, .o_shared_flag_pin, .o_shared_flag_pin_oe_n, .i_sp1_data_in, .i_sp1_rfs_in, .i_sp1_tfs_in,
    .o_sp1_data_out, .i_core_sp1_tx, .o_core_sp1_rx, .o_core_sp1_rfs, .o_core_sp1_tfs, .o_irq_request);
  rmp_ext_side rmp_ext_side_i (.i_reset_n(i_reset_n), .i_strap_level(strap_lvl), .i_ext_low(ext_low),
    .i_dev_out(o_shared_flag_pin), .i_dev_oe_n(o_shared_flag_pin_oe_n), .o_pin_level(i_shared_flag_pin));

  // 25 MHz clock and a hang guard well past the run length
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  // ====================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  task automatic look(input int n);
    cyc(n);
    @(negedge i_clk_sys);
  endtask : look
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(1); i_reg_addr <= a; i_reg_wdata <= d; i_reg_write <= 1'b1;
    cyc(1); i_reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    cyc(1); i_reg_addr <= a; i_reg_read <= 1'b1;
    cyc(1); i_reg_read <= 1'b0;
    @(negedge i_clk_sys); d = o_reg_rdata;
  endtask : rd
  // strap is driven only while reset is low, held five cycles
  task automatic do_reset(input logic lvl);
    cyc(1); strap_lvl <= lvl; i_reset_n <= 1'b0;
    cyc(5); i_reset_n <= 1'b1;
  endtask : do_reset

  // ====================
  // scenarios
  task automatic t_full;
    do_reset(1'b0);
    // strap now floats high on the pull-up; mode must not follow
    cyc(1); i_core_addr <= 14'h2A5C; i_core_byte_access <= 1'b1; i_core_byte_addr <= 8'hC3;
    i_core_data_drive <= 1'b1; i_core_wdata <= 24'h00BEEF; i_external_data_bus <= 24'h5A1E3C;
    look(4);
    chk("mode", 32'h0, o_mode_host);
    chk("addr", 32'h2A5C, o_external_address_bus);
    chk("data out", 32'hC3BEEF, o_external_data_bus);
    chk("data oe", 32'h0, o_external_data_bus_oe_n);
    chk("data in", 32'h5A1E3C, o_core_rdata);
    cyc(1); i_core_byte_access <= 1'b0; i_core_data_drive <= 1'b0;
    look(2);
    chk("data oe idle", 32'hFFFFFF, o_external_data_bus_oe_n);
    $display("test full mode done");
  endtask : t_full
  task automatic t_host;
    do_reset(1'b1);
    cyc(1); i_core_addr <= 14'h3FFF; i_host_port_addr_data_bus <= 16'h1234; i_host_port_select_n <= 1'b0;
    i_host_port_write_strobe_n <= 1'b0; i_core_host_drive <= 1'b1; i_core_host_rdata <= 16'h9876;
    i_core_host_ack <= 1'b1; i_core_data_drive <= 1'b1;
    look(4);
    chk("mode", 32'h1, o_mode_host);
    chk("addr", 32'h1, o_external_address_bus);
    chk("data oe", 32'hFF, o_external_data_bus_oe_n);
    chk("data in host", 32'h5A1E00, o_core_rdata);
    chk("core bus", 32'h1234, o_core_host_bus);
    chk("core wr", 32'h1, o_core_host_write & o_core_host_select);
    chk("ack", 32'h0, o_host_port_ack_n);
    chk("port out", 32'h9876, o_host_port_addr_data_bus);
    chk("port oe", 32'h0, o_host_port_addr_data_bus_oe_n);
    cyc(1); i_host_port_read_strobe_n <= 1'b0; i_host_port_write_strobe_n <= 1'b1; i_core_host_drive <= 1'b0;
    i_core_host_ack <= 1'b0; i_core_data_drive <= 1'b0; i_host_port_addr_latch <= 1'b1;
    look(4);
    chk("ack idle", 32'h1, o_host_port_ack_n);
    chk("core wr idle", 32'h0, o_core_host_write);
    chk("core rd", 32'h1, o_core_host_read);
    chk("core latch", 32'h1, o_core_host_addr_latch);
    chk("port oe idle", 32'hFFFF, o_host_port_addr_data_bus_oe_n);
    $display("test host mode done");
  endtask : t_host
  task automatic t_regs;
    logic [15:0] d;
    // reset values, unmapped places read zero
    for (int a = 0; a < 16; a++) begin
      if (a != 2 && a != 5) begin
        rd(a[3:0], d);
        chk("reg reset", 32'h0, d);
      end
    end
    rd(rmp_pkg::OFS_STATUS, d);
    chk("status", 32'h1, d);
    wr(rmp_pkg::OFS_FLAG_DIR, 16'hFFFF);
    rd(rmp_pkg::OFS_FLAG_DIR, d);
    chk("dir", 32'hFF, d);
    wr(rmp_pkg::OFS_FLAG_DIR, 16'h0000);
    $display("test registers done");
  endtask : t_regs
  task automatic t_irq;
    wr(rmp_pkg::OFS_IRQ_MASK, 16'h0001);
    cyc(1); ext_low <= 8'h10;
    look(4);
    chk("irq external", 32'h1, o_irq_request);
    cyc(1); ext_low <= 8'h00;
    look(4);
    chk("irq released", 32'h0, o_irq_request);
    wr(rmp_pkg::OFS_FLAG_DIR, 16'h0015);
    look(2);
    chk("flag oe", 32'hEA, o_shared_flag_pin_oe_n);
    chk("mode kept", 32'h1, o_mode_host);
    chk("irq by flag", 32'h1, o_irq_request);
    wr(rmp_pkg::OFS_IRQ_MASK, 16'h0000);
    look(2);
    chk("irq masked", 32'h0, o_irq_request);
    wr(rmp_pkg::OFS_FLAG_DIR, 16'h0000);
    $display("test interrupts done");
  endtask : t_irq
  task automatic t_serial;
    logic [15:0] d;
    cyc(1); i_sp1_data_in <= 1'b1; i_sp1_tfs_in <= 1'b0; i_core_sp1_tx <= 1'b1;
    look(4);
    chk("rx serial", 32'h1, o_core_sp1_rx);
    chk("tx serial", 32'h1, o_sp1_data_out);
    wr(rmp_pkg::OFS_SYS_CTRL, 16'h0001);
    wr(rmp_pkg::OFS_IRQ_MASK, 16'h0020);
    look(3);
    chk("rx alt", 32'h0, o_core_sp1_rx);
    chk("irq alt", 32'h20, o_irq_request);
    chk("tx alt", 32'h0, o_sp1_data_out);
    chk("rfs alt", 32'h0, o_core_sp1_rfs);
    rd(rmp_pkg::OFS_STATUS, d);
    chk("status alt", 32'h83, d);
    wr(rmp_pkg::OFS_SYS_CTRL, 16'h0000);
    look(3);
    chk("rx back", 32'h1, o_core_sp1_rx);
    chk("irq back", 32'h0, o_irq_request);
    chk("tx back", 32'h1, o_sp1_data_out);
    $display("test serial select done");
  endtask : t_serial
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    t_full();
    t_host();
    t_regs();
    t_irq();
    t_serial();
    close_out();
  end
endmodule : rmp_pin_config_bench

// ### verif/rmp_pin_config_chk.sv
// assertion checker for the reset-mode and pin-function block
`timescale 1ns/100ps
module rmp_pin_config_chk (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  // core and external bus
  input wire logic [13:0] i_core_addr,
  input wire logic        i_core_byte_access,
  input wire logic [7:0]  i_core_byte_addr,
  input wire logic        o_mode_host,
  input wire logic [13:0] o_external_address_bus,
  input wire logic [23:0] o_external_data_bus,
  input wire logic [23:0] o_external_data_bus_oe_n,
  // host port
  input wire logic        i_host_port_select_n,
  input wire logic        i_host_port_write_strobe_n,
  input wire logic        i_core_host_ack,
  input wire logic        o_host_port_ack_n,
  input wire logic        o_core_host_select,
  input wire logic        o_core_host_write
);
  // ====================
  // properties, one clock domain
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // host write request seen at the pins
  sequence s_host_wr;
    o_mode_host && !i_host_port_select_n && !i_host_port_write_strobe_n;
  endsequence
  AST_MODE_HOLD: assert property ($past(i_reset_n) |-> $stable(o_mode_host))
    else $error("memory mode changed while running");
  AST_ADDR_FULL: assert property (!o_mode_host |=> o_external_address_bus == $past(i_core_addr))
    else $error("full mode address not passed on");
  AST_ADDR_HOST: assert property (o_mode_host |=> o_external_address_bus == {13'h0, $past(i_core_addr[0])})
    else $error("host mode address not single bit");
  AST_BYTE_ADDR: assert property (!o_mode_host && i_core_byte_access |=>
    o_external_data_bus[23:16] == $past(i_core_byte_addr) && o_external_data_bus_oe_n[23:16] == 8'h00)
    else $error("byte address missing on upper data");
  AST_HOST_LOW_OE: assert property (o_mode_host |-> o_external_data_bus_oe_n[7:0] == 8'hFF)
    else $error("low data lines driven in host mode");
  AST_ACK: assert property (o_mode_host && i_core_host_ack |=> !o_host_port_ack_n)
    else $error("host acknowledge late");
  AST_ACK_FULL: assert property (!o_mode_host |-> o_host_port_ack_n)
    else $error("acknowledge in full mode");
  AST_HOST_WR: assert property (s_host_wr |-> ##2 (o_core_host_write && o_core_host_select))
    else $error("host write strobe not passed to core");
  AST_FULL_IDLE: assert property (!o_mode_host |-> !o_core_host_select && !o_core_host_write)
    else $error("host port active in full mode");
endmodule : rmp_pin_config_chk

bind rmp_pin_config rmp_pin_config_chk rmp_pin_config_chk_i (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_core_addr(i_core_addr),
  .i_core_byte_access(i_core_byte_access), .i_core_byte_addr(i_core_byte_addr), .o_mode_host(o_mode_host),
  .o_external_address_bus(o_external_address_bus), .o_external_data_bus(o_external_data_bus),
  .o_external_data_bus_oe_n(o_external_data_bus_oe_n), .i_host_port_select_n(i_host_port_select_n),
  .i_host_port_write_strobe_n(i_host_port_write_strobe_n), .i_core_host_ack(i_core_host_ack),
  .o_host_port_ack_n(o_host_port_ack_n), .o_core_host_select(o_core_host_select),
  .o_core_host_write(o_core_host_write));
